// >>> smc_pkg.sv
// package: sleep mode encodings, domain gate bundle, timing counts
package smc_pkg;

  // software-selectable sleep modes
  typedef enum logic [2:0] {
    SMC_MODE_IDLE,
    SMC_MODE_PDOWN,
    SMC_MODE_PSAVE,
    SMC_MODE_STBY,
    SMC_MODE_XSTBY
  } smc_mode_t;

  // run enables for each gated domain, high = running
  typedef struct packed {
    logic cpu;
    logic sram;
    logic timers;
    logic spi;
    logic irq;
    logic osc;
    logic async_tmr;
  } smc_gates_t;

  // all domains running
  localparam smc_gates_t SMC_GATES_RUN = 7'h7f;

  // oscillator start-up wait after power-down or power-save
  localparam int unsigned SMC_OSC_START_NS = 1000;
  localparam int unsigned SMC_CLK_NS       = 10;
  localparam int unsigned SMC_OSC_START_CYC =
    (SMC_OSC_START_NS + SMC_CLK_NS - 1) / SMC_CLK_NS;
  localparam int unsigned SMC_CNT_W = 8;

endpackage : smc_pkg

// >>> smc_gate_map.sv
// combinational map from sleep mode to domain run enables
`timescale 1ns/10ps
module smc_gate_map
  import smc_pkg::*;
(
  input  smc_pkg::smc_mode_t  mode,
  output smc_pkg::smc_gates_t gates
);
  import smc_pkg::*;

  // the mode decides which domains keep their clocks
  always_comb begin
    gates = '0;
    unique case (mode)
      // cpu halted; memory, timers, spi, irq alive
      SMC_MODE_IDLE: begin
        gates.sram      = 1'b1;
        gates.timers    = 1'b1;
        gates.spi       = 1'b1;
        gates.irq       = 1'b1;
        gates.osc       = 1'b1;
        gates.async_tmr = 1'b1;
      end
      // everything off, oscillator frozen
      SMC_MODE_PDOWN: begin
        gates = '0;
      end
      // only the asynchronous timer keeps time
      SMC_MODE_PSAVE: begin
        gates.async_tmr = 1'b1;
      end
      // oscillator kept hot for fast wake
      SMC_MODE_STBY: begin
        gates.osc = 1'b1;
      end
      // oscillator plus asynchronous timer
      SMC_MODE_XSTBY: begin
        gates.osc       = 1'b1;
        gates.async_tmr = 1'b1;
      end
      // illegal code: treat as deepest sleep
      default: begin
        gates = '0;
      end
    endcase
  end
endmodule : smc_gate_map

// >>> smc_sleep_ctrl.sv
// sleep controller: mode select, sleep entry, wake and oscillator restart
//
// Behaviour
// - five selectable modes, each gating different domains
// - idle: cpu stops, sram/timers/spi/irq run
// - power-down: oscillator stops until interrupt or reset
// - power-save: asynchronous timer keeps counting
// - standby: oscillator runs, no start-up delay
// - extended standby: oscillator and asynchronous timer run
`timescale 1ns/10ps
module smc_sleep_ctrl
  import smc_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst_b,
  input  wire logic                sleep_en,
  input  smc_pkg::smc_mode_t       mode_sel,
  input  wire logic                sleep_op,
  input  wire logic                wake_irq,
  input  wire logic                wake_async,
  output smc_pkg::smc_gates_t      gates,
  output logic                     sleeping,
  output logic                     wake_done
);
  import smc_pkg::*;

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WARM} smc_state_t;

  smc_state_t           state_reg;    // controller state
  smc_mode_t            mode_reg;     // mode latched at sleep entry
  smc_gates_t           sleep_gates;  // map output for latched mode
  smc_gates_t           gates_reg;    // registered domain enables
  logic [SMC_CNT_W-1:0] warm_cnt_reg; // oscillator start-up counter
  logic                 wake_done_reg;
  logic                 wake_hit;     // a source able to wake this mode

  localparam logic [SMC_CNT_W-1:0] WARM_LAST =
    SMC_CNT_W'(SMC_OSC_START_CYC - 1);

  // mode to gate decode
  smc_gate_map u_map (
    .mode  (mode_reg),
    .gates (sleep_gates)
  );

  // irq always wakes; async timer event wakes only where it runs
  always_comb begin
    wake_hit = wake_irq | (wake_async & sleep_gates.async_tmr);
  end

  // state machine: entry only from the sleep operation
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg <= ST_RUN;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          if (sleep_op && sleep_en) begin
            state_reg <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wake_hit) begin
            // a stopped oscillator must settle first
            state_reg <= sleep_gates.osc ? ST_RUN : ST_WARM;
          end
        end
        ST_WARM: begin
          if (warm_cnt_reg == WARM_LAST) begin
            state_reg <= ST_RUN;
          end
        end
      endcase
    end
  end

  // mode captured on entry so later writes cannot shift domains mid-sleep
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mode_reg <= SMC_MODE_IDLE;
    end else if (state_reg == ST_RUN && sleep_op && sleep_en) begin
      mode_reg <= mode_sel;
    end
  end

  // oscillator start-up counter
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      warm_cnt_reg <= '0;
    end else if (state_reg == ST_WARM) begin
      warm_cnt_reg <= warm_cnt_reg + SMC_CNT_W'(1);
    end else begin
      warm_cnt_reg <= '0;
    end
  end

  // domain enables: full run except while sleeping or warming
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      gates_reg <= SMC_GATES_RUN;
    end else if (state_reg == ST_RUN && sleep_op && sleep_en) begin
      gates_reg <= '0; // refined next cycle by the map
    end else if (state_reg == ST_SLEEP && !wake_hit) begin
      gates_reg <= sleep_gates;
    end else if (state_reg == ST_SLEEP) begin
      // waking: oscillator first, cpu after warm-up if needed
      gates_reg     <= sleep_gates.osc ? SMC_GATES_RUN : '0;
      gates_reg.osc <= 1'b1;
    end else if (state_reg == ST_WARM) begin
      if (warm_cnt_reg == WARM_LAST) begin
        gates_reg <= SMC_GATES_RUN;
      end else begin
        gates_reg     <= '0;
        gates_reg.osc <= 1'b1;
      end
    end else begin
      gates_reg <= SMC_GATES_RUN;
    end
  end

  // one-cycle pulse when execution resumes
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wake_done_reg <= 1'b0;
    end else begin
      wake_done_reg <= (state_reg == ST_SLEEP && wake_hit
                        && sleep_gates.osc)
                    || (state_reg == ST_WARM && warm_cnt_reg == WARM_LAST);
    end
  end

  assign gates     = gates_reg;
  assign sleeping  = (state_reg != ST_RUN);
  assign wake_done = wake_done_reg;

  // ---- assertions ----
  AST_NO_SLEEP_WITHOUT_OP: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_RUN && !(sleep_op && sleep_en)) |=> !sleeping)
    else $error("sleep entered without sleep op");

  AST_CPU_OFF_ASLEEP: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_SLEEP && $past(state_reg) == ST_SLEEP
     && !$past(wake_hit)) |-> !gates.cpu)
    else $error("cpu clock running during sleep");

  AST_IDLE_DOMAINS: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_SLEEP && mode_reg == SMC_MODE_IDLE && !wake_hit)
    |=> (gates.sram && gates.timers && gates.spi && gates.irq))
    else $error("idle lost a running domain");

  AST_PDOWN_ALL_OFF: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_SLEEP && mode_reg == SMC_MODE_PDOWN && !wake_hit)
    |=> gates == '0)
    else $error("power-down left a domain on");

  AST_PSAVE_ASYNC: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_SLEEP && mode_reg == SMC_MODE_PSAVE && !wake_hit)
    |=> (gates.async_tmr && !gates.osc))
    else $error("power-save gating wrong");

  AST_STBY_FAST_WAKE: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_SLEEP && mode_reg == SMC_MODE_STBY && wake_irq)
    |=> (wake_done && gates.cpu && !sleeping))
    else $error("standby wake not immediate");

  AST_XSTBY_DOMAINS: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_SLEEP && mode_reg == SMC_MODE_XSTBY && !wake_hit)
    |=> (gates.osc && gates.async_tmr && !gates.timers))
    else $error("extended standby gating wrong");

  AST_PDOWN_WARM_WAKE: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_SLEEP && mode_reg == SMC_MODE_PDOWN && wake_irq)
    |=> (sleeping && !gates.cpu) ##[1:200] wake_done)
    else $error("power-down wake timing wrong");

  COV_IDLE_WAKE: cover property (@(posedge mclk) disable iff (!rst_b)
    state_reg == ST_SLEEP && mode_reg == SMC_MODE_IDLE && wake_irq);
  COV_PDOWN_WAKE: cover property (@(posedge mclk) disable iff (!rst_b)
    state_reg == ST_WARM ##1 wake_done);
  COV_PSAVE_ASYNC: cover property (@(posedge mclk) disable iff (!rst_b)
    state_reg == ST_SLEEP && mode_reg == SMC_MODE_PSAVE && wake_async);
  COV_STBY_WAKE: cover property (@(posedge mclk) disable iff (!rst_b)
    state_reg == ST_SLEEP && mode_reg == SMC_MODE_STBY && wake_irq);
  COV_XSTBY_ASYNC: cover property (@(posedge mclk) disable iff (!rst_b)
    state_reg == ST_SLEEP && mode_reg == SMC_MODE_XSTBY && wake_async);

  // resume pulse must never stretch into a second cycle
  AST_WAKE_PULSE_ONE: assert property (
    @(posedge mclk) disable iff (!rst_b)
    wake_done |=> !wake_done)
    else $error("wake pulse longer than one cycle");

  // entry cycle gates everything before the map settles
  AST_ENTRY_ALL_OFF: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_RUN && sleep_op && sleep_en)
    |=> (sleeping && gates == '0))
    else $error("sleep entry did not gate every domain");

  // no sleep op, no gating
  AST_RUN_FULL: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_RUN && !(sleep_op && sleep_en))
    |=> gates == SMC_GATES_RUN)
    else $error("domain gated while running");

  // restart wait: oscillator on, cpu still held
  AST_WARM_OSC_ONLY: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_WARM) |-> (gates.osc && !gates.cpu && sleeping))
    else $error("oscillator restart gating wrong");

  // timer events cannot wake modes where the timer is stopped
  AST_ASYNC_REFUSED: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_SLEEP && wake_async && !wake_irq
     && (mode_reg == SMC_MODE_STBY || mode_reg == SMC_MODE_PDOWN))
    |=> sleeping)
    else $error("timer event woke a mode it cannot wake");

  // latched mode must not move while asleep
  AST_MODE_HELD: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (state_reg != ST_RUN) |=> $stable(mode_reg))
    else $error("mode changed while asleep");

endmodule : smc_sleep_ctrl

// >>> smc_sleep_ctrl_tb.sv
// self-checking bench for the sleep mode controller
`timescale 1ns/10ps
module smc_sleep_ctrl_tb;
  import smc_pkg::*;
  localparam int LIMIT = 3000; // cycles; whole run needs about 360
  logic       mclk       = 1'b0;
  logic       rst_b      = 1'b0; // held low for the first 3 cycles
  logic       sleep_en   = 1'b0;
  smc_mode_t  mode_sel   = SMC_MODE_IDLE;
  logic       sleep_op   = 1'b0;
  logic       wake_irq   = 1'b0;
  logic       wake_async = 1'b0;
  smc_gates_t gates;
  logic       sleeping;
  logic       wake_done;
  int         errors     = 0;
  int         n_tests    = 0;
  int         cyc        = 0;

  // 100 MHz clock
  always #5 mclk = ~mclk;

  smc_sleep_ctrl dut (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .sleep_en   (sleep_en),
    .mode_sel   (mode_sel),
    .sleep_op   (sleep_op),
    .wake_irq   (wake_irq),
    .wake_async (wake_async),
    .gates      (gates),
    .sleeping   (sleeping),
    .wake_done  (wake_done)
  );

  // counts and verdict, the single exit of the run
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // compare tasks, one per kind of result
  task automatic chk_gates(input smc_gates_t got, input smc_gates_t exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t gates got %h exp %h", $time, got, exp);
    end
  endtask : chk_gates

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t flag got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_cnt(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      errors++;
      $display("BAD %0t cycles got %h exp %h", $time, got, exp);
    end
  endtask : chk_cnt

  // hang guard: a stuck wait must still reach the verdict
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      finish_test();
    end
  end

  // sleep op with entry disabled must leave everything running
  task automatic refuse_test;
    @(negedge mclk);
    sleep_en = 1'b0;
    sleep_op = 1'b1;
    @(negedge mclk);
    sleep_op = 1'b0;
    chk_bit(sleeping, 1'b0);
    chk_gates(gates, SMC_GATES_RUN);
  endtask : refuse_test

  // reset in mid-sleep must restore full run at once
  task automatic reset_test;
    @(negedge mclk);
    mode_sel = SMC_MODE_PDOWN;
    sleep_en = 1'b1;
    sleep_op = 1'b1;
    @(negedge mclk);
    sleep_op = 1'b0;
    chk_bit(sleeping, 1'b1);
    rst_b = 1'b0;
    @(negedge mclk);
    rst_b = 1'b1;
    chk_gates(gates, SMC_GATES_RUN);
    chk_bit(sleeping, 1'b0);
  endtask : reset_test

  // enter a mode, optionally try a refused async wake, then wake it
  task automatic run_mode(input smc_mode_t m, input smc_gates_t map,
                          input logic try_async, input logic async_wakes,
                          input logic slow);
    int n;
    n = 0;
    @(negedge mclk);
    mode_sel = m;
    sleep_en = 1'b1;
    sleep_op = 1'b1;
    @(negedge mclk);
    sleep_op = 1'b0;
    chk_bit(sleeping, 1'b1);
    chk_gates(gates, 7'h00);
    @(negedge mclk);
    chk_gates(gates, map);
    // a second sleep op while asleep must change nothing
    mode_sel = (m == SMC_MODE_IDLE) ? SMC_MODE_PDOWN : SMC_MODE_IDLE;
    sleep_op = 1'b1;
    @(negedge mclk);
    sleep_op = 1'b0;
    chk_bit(sleeping, 1'b1);
    chk_gates(gates, map);
    // timer event in a mode it cannot wake: must be ignored
    if (try_async && !async_wakes) begin
      wake_async = 1'b1;
      @(negedge mclk);
      wake_async = 1'b0;
      chk_bit(sleeping, 1'b1);
      chk_gates(gates, map);
    end
    if (try_async && async_wakes) wake_async = 1'b1;
    else wake_irq = 1'b1;
    // one-cycle wake pulse, then count cycles to resume
    do begin
      @(negedge mclk);
      wake_async = 1'b0;
      wake_irq   = 1'b0;
      n++;
      if (slow && n == 1) chk_gates(gates, 7'h02);
    end while (wake_done !== 1'b1 && n < 200);
    chk_cnt(n, slow ? int'(1 + SMC_OSC_START_CYC) : 1);
    chk_gates(gates, SMC_GATES_RUN);
    chk_bit(sleeping, 1'b0);
    @(negedge mclk);
    chk_bit(wake_done, 1'b0);
  endtask : run_mode

  // main sequence: reset, refusal, every mode
  initial begin
    repeat (3) @(negedge mclk);
    chk_gates(gates, SMC_GATES_RUN);
    chk_bit(sleeping, 1'b0);
    chk_bit(wake_done, 1'b0);
    rst_b = 1'b1;
    refuse_test();
    run_mode(SMC_MODE_IDLE, 7'h3f, 1'b1, 1'b1, 1'b0);
    run_mode(SMC_MODE_PDOWN, 7'h00, 1'b1, 1'b0, 1'b1);
    run_mode(SMC_MODE_PSAVE, 7'h01, 1'b1, 1'b1, 1'b1);
    run_mode(SMC_MODE_STBY, 7'h02, 1'b1, 1'b0, 1'b0);
    run_mode(SMC_MODE_XSTBY, 7'h03, 1'b0, 1'b0, 1'b0);
    run_mode(SMC_MODE_XSTBY, 7'h03, 1'b1, 1'b1, 1'b0);
    // unused mode code falls back to deepest sleep
    run_mode(smc_mode_t'(3'h5), 7'h00, 1'b0, 1'b0, 1'b1);
    reset_test();
    run_mode(SMC_MODE_STBY, 7'h02, 1'b0, 1'b0, 1'b0);
    finish_test();
  end

endmodule : smc_sleep_ctrl_tb
